// *** inc/asrc_pkg.sv ***
package asrc_pkg;
   localparam int ASRC_ADDR_W = 18;
   localparam int ASRC_DATA_W = 4;
   localparam int ASRC_CLK_PS = 25000;
   // Timing figures in their own units
   localparam int ASRC_POWERUP_WAIT_US = 100;
   localparam int ASRC_READ_PERIOD_NS = 10;
   localparam int ASRC_WRITE_PERIOD_NS = 10;
   localparam int ASRC_WRITE_STROBE_WIDTH_NS = 7;
   localparam int ASRC_ADDR_TO_DATA_NS = 10;
   localparam int ASRC_WRITE_FLOAT_NS = 5;
   localparam int ASRC_WRITE_SETUP_NS = 6;
   // Cycle counts, least times rounded up, minimum one
   function automatic int asrc_cyc(input int ps);
      int c;
      c = (ps + ASRC_CLK_PS - 1) / ASRC_CLK_PS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int ASRC_POWERUP_CYC = asrc_cyc(ASRC_POWERUP_WAIT_US * 1000000);
   localparam int ASRC_RD_CYC = asrc_cyc(ASRC_ADDR_TO_DATA_NS * 1000) + 1;
   localparam int ASRC_WE_CYC = asrc_cyc((ASRC_WRITE_FLOAT_NS + ASRC_WRITE_SETUP_NS) * 1000);
   localparam int ASRC_SYNC_CYC = 2;
   localparam int ASRC_CNT_W = 16;
   typedef enum logic [2:0] {
      ASRC_S_POWERUP = 3'h0,
      ASRC_S_IDLE = 3'h1,
      ASRC_S_READ = 3'h3,
      ASRC_S_WRITE = 3'h2,
      ASRC_S_WEND = 3'h6
   } asrc_state_t;
endpackage

// *** logic/asrc_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module asrc_ctrl
   import asrc_pkg::*;
#(
   parameter int POWERUP_CYC = ASRC_POWERUP_CYC
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // User request
   input wire logic req_valid_i,
   input wire logic req_write_i,
   input wire logic [ASRC_ADDR_W-1:0] req_addr_i,
   input wire logic [ASRC_DATA_W-1:0] req_wdata_i,
   output logic req_ready_o,
   output logic rsp_valid_o,
   output logic [ASRC_DATA_W-1:0] rsp_rdata_o,
   // Memory pins
   output logic [ASRC_ADDR_W-1:0] word_address_18b_o,
   output logic chip_sel_n_o,
   output logic out_en_n_o,
   output logic write_n_o,
   input wire logic [ASRC_DATA_W-1:0] data_bus_4b_i,
   output logic [ASRC_DATA_W-1:0] data_bus_4b_o,
   output logic data_bus_4b_oe_o
);
   asrc_state_t state_r, state_nxt;
   logic [ASRC_CNT_W-1:0] cnt_r, cnt_nxt;
   logic [ASRC_ADDR_W-1:0] addr_r;
   logic [ASRC_DATA_W-1:0] wdata_r, rdata_r;
   logic [ASRC_DATA_W-1:0] din_s1_r, din_s2_r;
   logic cs_n_r, oe_n_r, we_n_r, drv_r, rsp_r;
   wire cnt_done = (cnt_r == '0);
   wire idle = (state_r == ASRC_S_IDLE);
   wire take = idle && req_valid_i;
   wire [ASRC_CNT_W-1:0] rd_len = ASRC_CNT_W'(ASRC_RD_CYC + ASRC_SYNC_CYC);
   wire [ASRC_CNT_W-1:0] we_len = ASRC_CNT_W'(ASRC_WE_CYC - 1);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_done ? cnt_r : cnt_r - ASRC_CNT_W'(1);
      unique case (state_r)
         ASRC_S_POWERUP: begin
            if (cnt_done) begin
               state_nxt = ASRC_S_IDLE;
            end
         end
         ASRC_S_IDLE: begin
            if (take) begin
               state_nxt = req_write_i ? ASRC_S_WRITE : ASRC_S_READ;
               cnt_nxt = req_write_i ? we_len : rd_len;
            end
         end
         ASRC_S_READ: begin
            if (cnt_done) begin
               state_nxt = ASRC_S_IDLE;
            end
         end
         ASRC_S_WRITE: begin
            if (cnt_done) begin
               state_nxt = ASRC_S_WEND;
            end
         end
         ASRC_S_WEND: begin
            state_nxt = ASRC_S_IDLE;
         end
         default: begin
            state_nxt = ASRC_S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         state_r <= ASRC_S_POWERUP;
         cnt_r <= ASRC_CNT_W'(POWERUP_CYC - 1);
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Pin strobes: address set on the same edge that select falls, data held through write end
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         addr_r <= '0;
         wdata_r <= '0;
         cs_n_r <= 1'b1;
         oe_n_r <= 1'b1;
         we_n_r <= 1'b1;
         drv_r <= 1'b0;
      end else begin
         if (take) begin
            addr_r <= req_addr_i;
            wdata_r <= req_wdata_i;
         end
         cs_n_r <= !(state_nxt == ASRC_S_READ || state_nxt == ASRC_S_WRITE);
         oe_n_r <= !(state_nxt == ASRC_S_READ);
         we_n_r <= !(state_nxt == ASRC_S_WRITE);
         drv_r <= (state_nxt == ASRC_S_WRITE) || (state_nxt == ASRC_S_WEND);
      end
   end

   // Read data passes two flops before capture
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         din_s1_r <= '0;
         din_s2_r <= '0;
         rdata_r <= '0;
         rsp_r <= 1'b0;
      end else begin
         din_s1_r <= data_bus_4b_i;
         din_s2_r <= din_s1_r;
         rsp_r <= (state_r == ASRC_S_READ) && cnt_done;
         if ((state_r == ASRC_S_READ) && cnt_done) begin
            rdata_r <= din_s2_r;
         end
      end
   end

   assign req_ready_o = idle;
   assign rsp_valid_o = rsp_r;
   assign rsp_rdata_o = rdata_r;
   assign word_address_18b_o = addr_r;
   assign chip_sel_n_o = cs_n_r;
   assign out_en_n_o = oe_n_r;
   assign write_n_o = we_n_r;
   assign data_bus_4b_o = wdata_r;
   assign data_bus_4b_oe_o = drv_r;

   logic [ASRC_CNT_W-1:0] low_cnt_r;
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         low_cnt_r <= '0;
      end else begin
         low_cnt_r <= we_n_r ? '0 : low_cnt_r + ASRC_CNT_W'(1);
      end
   end

   // Cycles since reset, saturating, for the power-up wait check
   logic [ASRC_CNT_W-1:0] since_rst_r;
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         since_rst_r <= '0;
      end else if (since_rst_r != '1) begin
         since_rst_r <= since_rst_r + ASRC_CNT_W'(1);
      end
   end

   no_early_access_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (state_r == ASRC_S_POWERUP) |-> chip_sel_n_o)
      else $error("access before power-up wait");
   we_high_read_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !out_en_n_o |-> write_n_o)
      else $error("write strobe low during read");
   we_width_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ($rose(write_n_o) && !$past(rst_i)) |-> (low_cnt_r >= ASRC_CNT_W'(ASRC_WE_CYC)))
      else $error("write strobe too short");
   data_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $rose(write_n_o) |-> data_bus_4b_oe_o && $stable(data_bus_4b_o))
      else $error("write data not held at write end");
   no_contention_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      data_bus_4b_oe_o |-> out_en_n_o)
      else $error("driving while device enabled");
   addr_stable_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (!chip_sel_n_o && !$past(chip_sel_n_o)) |-> $stable(word_address_18b_o))
      else $error("address moved during cycle");
   read_len_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $fell(out_en_n_o) |-> !out_en_n_o [*2] ##1 !out_en_n_o)
      else $error("read cycle too short");
   resp_after_read_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      rsp_valid_o |-> out_en_n_o && !$past(out_en_n_o) && !$past(out_en_n_o, 5))
      else $error("response without read cycle");

   // Pin and request/response protocol checks
   powerup_wait_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      req_ready_o |-> (since_rst_r >= ASRC_CNT_W'(POWERUP_CYC)))
      else $error("ready before power-up wait ended");
   read_pins_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !out_en_n_o |-> !chip_sel_n_o && !data_bus_4b_oe_o)
      else $error("read without select or with bus driven");
   write_pins_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !write_n_o |-> !chip_sel_n_o && data_bus_4b_oe_o)
      else $error("write without select or without data");
   write_oe_high_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !write_n_o |-> out_en_n_o)
      else $error("output enable low during write");
   drive_release_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $fell(data_bus_4b_oe_o) |-> $past(write_n_o) && $past(chip_sel_n_o))
      else $error("data released before write ended");
   wdata_steady_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (data_bus_4b_oe_o && $past(data_bus_4b_oe_o)) |-> $stable(data_bus_4b_o))
      else $error("write data changed while driven");
   rsp_pulse_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      rsp_valid_o |=> !rsp_valid_o)
      else $error("response longer than one cycle");
   idle_deselect_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      idle |-> chip_sel_n_o && write_n_o && out_en_n_o && !data_bus_4b_oe_o)
      else $error("pins active while idle");
endmodule
`default_nettype wire

// *** verif/asrc_sram_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module asrc_sram_model
   import asrc_pkg::*;
(
   // Memory pins
   input wire logic [ASRC_ADDR_W-1:0] addr_i,
   input wire logic cs_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic [ASRC_DATA_W-1:0] dq_i,
   output logic [ASRC_DATA_W-1:0] dq_o,
   output logic drive_o
);
   logic [ASRC_DATA_W-1:0] mem [logic [ASRC_ADDR_W-1:0]];
   logic [ASRC_DATA_W-1:0] last_q = 4'h0;
   logic wr_open = 1'b0;
   wire wr_act = !cs_n_i && !we_n_i;
   wire rd_act = !cs_n_i && !oe_n_i && we_n_i;
   // Write opens on the overlap, taken at the first rising strobe
   always @(wr_act) begin
      if (wr_act === 1'b1) begin
         wr_open = 1'b1;
      end else if (wr_open && wr_act === 1'b0) begin
         mem[addr_i] = dq_i;
         wr_open = 1'b0;
      end
   end
   // Float shows inverted data, drive starts late with unknown data, stops at once
   initial begin
      drive_o = 1'b0;
      dq_o = 4'h5;
      forever begin
         @(rd_act or addr_i);
         if (rd_act !== 1'b1) begin
            drive_o = 1'b0;
            dq_o = ~last_q;
         end else begin
            #3;
            drive_o = rd_act;
            dq_o = 'x;
            #7;
            last_q = mem.exists(addr_i) ? mem[addr_i] : 4'h0;
            drive_o = rd_act;
            dq_o = rd_act ? last_q : ~last_q;
         end
      end
   end
endmodule
`default_nettype wire

// *** verif/test_async_sram_256kx4_port.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin fail_count++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module test_async_sram_256kx4_port
   import asrc_pkg::*;
;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic req_valid_i = 1'b0;
   logic req_write_i = 1'b0;
   logic [17:0] req_addr_i = 18'h0;
   logic [3:0] req_wdata_i = 4'h0;
   wire req_ready_o, rsp_valid_o, cs_n, oe_n, we_n, dut_oe, mem_drv;
   wire [3:0] rsp_rdata_o, dut_dq, mem_dq, bus;
   wire [17:0] addr;
   int fail_count = 0;
   int compares = 0;
   int cyc = 0;
   logic [3:0] ref_mem [logic [17:0]];
   assign bus = dut_oe ? dut_dq : mem_dq;
   asrc_ctrl #(.POWERUP_CYC(4)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_addr_i(req_addr_i),
      .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
      .rsp_rdata_o(rsp_rdata_o), .word_address_18b_o(addr), .chip_sel_n_o(cs_n),
      .out_en_n_o(oe_n), .write_n_o(we_n), .data_bus_4b_i(bus), .data_bus_4b_o(dut_dq),
      .data_bus_4b_oe_o(dut_oe));
   asrc_sram_model mem (.addr_i(addr), .cs_n_i(cs_n), .oe_n_i(oe_n), .we_n_i(we_n),
      .dq_i(bus), .dq_o(mem_dq), .drive_o(mem_drv));
   initial forever #12.5 clk_sys_i = ~clk_sys_i;
   task automatic test_done();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         test_done();
      end
   end
   // Pin monitor
   always @(negedge clk_sys_i) begin
      if (!rst_i) begin
         `CHK("bus clash", 1'b0, dut_oe && mem_drv)
         if (!oe_n) `CHK("strobe in read", 1'b1, we_n)
      end
   end
   task automatic op(input bit wr, input logic [17:0] a, input logic [3:0] d);
      int n;
      n = 0;
      req_valid_i <= 1'b1;
      req_write_i <= wr;
      req_addr_i <= a;
      req_wdata_i <= d;
      do begin @(posedge clk_sys_i); n++; end while (req_ready_o !== 1'b1 && n < 100);
      `CHK("request taken", 1'b1, req_ready_o)
      req_valid_i <= 1'b0;
      n = 0;
      if (wr) begin
         ref_mem[a] = d;
         @(posedge clk_sys_i);
      end else begin
         do begin @(posedge clk_sys_i); n++; end while (rsp_valid_o !== 1'b1 && n < 50);
         `CHK("read answer", 1'b1, rsp_valid_o)
         `CHK("read data", ref_mem.exists(a) ? ref_mem[a] : 4'h0, rsp_rdata_o)
      end
   endtask
   initial begin
      void'($urandom(6891));
      repeat (10) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      req_valid_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      `CHK("ready early", 1'b0, req_ready_o)
      `CHK("early access", 1'b1, cs_n)
      $display("test powerup done");
      op(1'b1, 18'h0, 4'hA);
      op(1'b1, 18'h3FFFF, 4'h5);
      op(1'b0, 18'h0, 4'h0);
      op(1'b0, 18'h3FFFF, 4'h0);
      op(1'b1, 18'h0, 4'hF);
      op(1'b0, 18'h0, 4'h0);
      $display("test boundary done");
      repeat (60) op(1'($urandom), {2'($urandom), 12'h0, 4'($urandom)}, 4'($urandom));
      $display("test random done");
      repeat (4) @(posedge clk_sys_i);
      rst_i <= 1'b1;
      repeat (10) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      `CHK("ready after reset", 1'b0, req_ready_o)
      `CHK("access after reset", 1'b1, cs_n)
      op(1'b0, 18'h3FFFF, 4'h0);
      op(1'b0, 18'h0, 4'h0);
      $display("test reset done");
      test_done();
   end
endmodule
`default_nettype wire
